/* hdl/scisp_pkg.sv */
// constants, states and carrier types of the hash coprocessor serial port
package scisp_pkg;

  // two flip-flops on every pin before device-clock logic reads it; the link shifter samples the data pin directly on the bus clock
  localparam int SYNC_STAGES = 2;

  // device clock figures
  localparam int CLK_PERIOD_NS = 25;

  // slave address: fixed bits (arbitrary neutral value) and strap positions
  localparam logic [6:0] ADDR_BASE = 7'h40;
  localparam int SLAVE_ADDR_BIT_0_POS = 0;
  localparam int SLAVE_ADDR_BIT_2_POS = 2;
  localparam int SLAVE_ADDR_BIT_4_POS = 4;
  localparam int STRAP_WIDTH = 3;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  // address byte layout
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int RW_POS = 0;
  localparam logic RW_READ = 1'b1;

  // byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // open-drain data line: enable is low while pulling the wire low
  localparam logic OE_N_DRIVE = 1'b0;
  localparam logic OE_N_RELEASE = 1'b1;
  localparam logic SDA_LOW = 1'b0;

  // idle bus reads high on both lines
  localparam logic [1:0] PIN_RESET = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK,
    ST_IGNORE
  } scisp_state_t;

  // received byte towards the device core
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } scisp_rx_t;

  // bus events seen on the synchronised pins
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } scisp_bus_ev_t;

  // one-cycle notices to the device core
  typedef struct packed {
    logic start;
    logic stop;
    logic tx_load;
    logic master_nack;
  } scisp_note_t;

endpackage

/* hdl/scisp_sync.sv */
// two-flop synchroniser for pins entering the device clock domain
`timescale 1ns/100ps
module scisp_sync
  import scisp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* hdl/scisp_port.sv */
// serial slave port of the hash coprocessor: framing, address, ack, data
//
// Notes on behaviour
// (RULE1) falling data while clock high is a start; device detects it
// (RULE2) three address bits come from the three strap pins
// (RULE3) last address bit: zero master writes, one device returns data
// (RULE4) bytes go most significant bit first, then one acknowledge bit
// (RULE5) rising data while clock high is a stop; device detects it
// (RULE6) stops are ignored until own address was received and acknowledged
// (RULE7) repeated start without stop opens a fresh transfer
// (RULE8) data changes only while clock low, stable through clock high
// (RULE9) one clock pulse per bit, captured at the rising clock edge
// (RULE10) device puts each read bit out at the preceding falling edge
// (RULE11) master makes every clock pulse, data and acknowledge alike
// (RULE12) master releases data early enough before a read phase
// (RULE13) receiver acknowledges by holding data low in ninth pulse
// (RULE14) while busy, own address is not acknowledged, data stays released
// (RULE15) refused bytes after the address get no acknowledge
// (RULE16) after a missing acknowledge, master restarts or stops then starts
// (RULE17) master marks last read byte by leaving acknowledge high
// (RULE18) on master not-acknowledge device stops sending, releases data
// (RULE19) clock line is input only, never held low
// (RULE20) data line is only pulled low or released
// (RULE21) on address mismatch stay released until the next start
`timescale 1ns/100ps
module scisp_port
  import scisp_pkg::*;
(
  // device clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // serial bus pins; clock is input only
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // address strap pins
  input wire logic addr_strap_pin_0_in,
  input wire logic addr_strap_pin_1_in,
  input wire logic addr_strap_pin_2_in,
  // device core: status and decisions
  input wire logic busy_in,
  input wire logic rx_accept_in,
  input wire logic [7:0] tx_byte_in,
  // device core: received data and notices
  output scisp_rx_t rx_out,
  output scisp_note_t note_out,
  output logic addressed_out,
  output logic read_mode_out
);

  // ---------------------------------------------------------------
  // link side: runs on the bus clock itself
  // ---------------------------------------------------------------
  logic [7:0] link_shift_q;

  // capture every bit at its rising clock edge, msb first
  always_ff @(posedge scl_in) begin
    link_shift_q <= {link_shift_q[6:0], sda_in}; // see (RULE9) (RULE4)
  end

  // ---------------------------------------------------------------
  // pin synchronisers into the device clock domain
  // ---------------------------------------------------------------
  logic [1:0] pins_s;
  logic [2:0] strap_s;
  logic scl_s;
  logic sda_s;

  scisp_sync #(
    .WIDTH(2),
    .RESET_VAL(PIN_RESET)
  ) u_pin_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );

  scisp_sync #(
    .WIDTH(STRAP_WIDTH),
    .RESET_VAL(STRAP_RESET)
  ) u_strap_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in({addr_strap_pin_2_in, addr_strap_pin_1_in,
               addr_strap_pin_0_in}),
    .sync_out(strap_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ---------------------------------------------------------------
  // bus event detection
  // ---------------------------------------------------------------
  logic scl_p_q;
  logic sda_p_q;
  scisp_bus_ev_t ev;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // data edges count as conditions only with clock high on both samples
  always_comb begin
    ev.start = scl_s & scl_p_q & sda_p_q & ~sda_s; // see (RULE1) (RULE7)
    ev.stop = scl_s & scl_p_q & ~sda_p_q & sda_s; // see (RULE5)
    ev.rise = scl_s & ~scl_p_q;
    ev.fall = ~scl_s & scl_p_q;
  end

  // ---------------------------------------------------------------
  // own address, straps taken once the synchroniser has refilled
  // ---------------------------------------------------------------
  logic strap_taken_q;
  logic [1:0] strap_wait_q;
  logic [6:0] own_addr_q;

  // synchroniser holds its reset value for two clocks after release
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      strap_wait_q <= 2'h0;
    end else if (strap_wait_q != 2'(SYNC_STAGES)) begin
      strap_wait_q <= strap_wait_q + 2'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      strap_taken_q <= 1'b0;
      own_addr_q <= ADDR_BASE;
    end else if (!strap_taken_q && strap_wait_q == 2'(SYNC_STAGES)) begin
      strap_taken_q <= 1'b1;
      own_addr_q[SLAVE_ADDR_BIT_0_POS] <= strap_s[0]; // see (RULE2)
      own_addr_q[SLAVE_ADDR_BIT_2_POS] <= strap_s[1]; // see (RULE2)
      own_addr_q[SLAVE_ADDR_BIT_4_POS] <= strap_s[2]; // see (RULE2)
    end
  end

  // ---------------------------------------------------------------
  // received byte crossing: link shifter is stable from its rising
  // edge to the next one, taken after the synchronised rise
  // ---------------------------------------------------------------
  logic [7:0] rx_cap_q;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rx_cap_q <= BYTE_RESET;
    end else if (ev.rise) begin
      rx_cap_q <= link_shift_q;
    end
  end

  // ---------------------------------------------------------------
  // transfer sequencing
  // ---------------------------------------------------------------
  scisp_state_t state_q;
  scisp_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_sh_d;
  logic oe_n_q;
  logic oe_n_d;
  logic addressed_q;
  logic addressed_d;
  logic read_q;
  logic read_d;
  logic nack_seen_q;
  logic nack_seen_d;
  logic rx_valid_d;
  scisp_note_t note_d;
  logic addr_match;

  assign addr_match = (rx_cap_q[ADDR_MSB:ADDR_LSB] == own_addr_q);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    tx_sh_d = tx_sh_q;
    oe_n_d = oe_n_q;
    addressed_d = addressed_q;
    read_d = read_q;
    nack_seen_d = nack_seen_q;
    rx_valid_d = 1'b0;
    note_d = '0;
    if (ev.start) begin
      // a start or repeated start always reopens address reception
      state_d = ST_ADDR; // see (RULE7) (RULE1)
      cnt_d = CNT_RESET;
      oe_n_d = OE_N_RELEASE;
      addressed_d = 1'b0;
      read_d = 1'b0;
      nack_seen_d = 1'b0;
      note_d.start = 1'b1;
    end else if (ev.stop) begin
      if (addressed_q) begin // see (RULE6)
        state_d = ST_IDLE; // see (RULE5)
        oe_n_d = OE_N_RELEASE;
        addressed_d = 1'b0;
        read_d = 1'b0;
        note_d.stop = 1'b1;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          oe_n_d = OE_N_RELEASE;
        end
        ST_ADDR: begin
          if (ev.rise) begin
            cnt_d = cnt_q + CNT_STEP; // see (RULE9)
          end else if (ev.fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = CNT_RESET;
            if (addr_match && !busy_in) begin // see (RULE14)
              state_d = ST_ADDR_ACK;
              oe_n_d = OE_N_DRIVE; // see (RULE13)
              addressed_d = 1'b1;
              read_d = (rx_cap_q[RW_POS] == RW_READ); // see (RULE3)
            end else begin
              state_d = ST_IGNORE; // see (RULE21) (RULE14)
              oe_n_d = OE_N_RELEASE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (ev.fall) begin
            cnt_d = CNT_RESET;
            if (read_q) begin
              // first read bit goes out at the ack pulse falling edge
              state_d = ST_RD;
              tx_sh_d = tx_byte_in;
              oe_n_d = tx_byte_in[7] ? OE_N_RELEASE : OE_N_DRIVE; // see (RULE10)
              note_d.tx_load = 1'b1;
            end else begin
              state_d = ST_WR;
              oe_n_d = OE_N_RELEASE;
            end
          end
        end
        ST_WR: begin
          if (ev.rise) begin
            cnt_d = cnt_q + CNT_STEP;
            rx_valid_d = (cnt_q == BITS_PER_BYTE - CNT_STEP);
          end else if (ev.fall && cnt_q == BITS_PER_BYTE) begin
            state_d = ST_WR_ACK;
            cnt_d = CNT_RESET;
            oe_n_d = rx_accept_in ? OE_N_DRIVE : OE_N_RELEASE; // see (RULE15)
          end
        end
        ST_WR_ACK: begin
          if (ev.fall) begin
            state_d = ST_WR;
            oe_n_d = OE_N_RELEASE;
          end
        end
        ST_RD: begin
          if (ev.rise) begin
            cnt_d = cnt_q + CNT_STEP;
          end else if (ev.fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              // hand the line to the master for its acknowledge
              state_d = ST_RD_ACK;
              cnt_d = CNT_RESET;
              oe_n_d = OE_N_RELEASE;
            end else begin
              tx_sh_d = {tx_sh_q[6:0], 1'b0}; // see (RULE4)
              oe_n_d = tx_sh_q[6] ? OE_N_RELEASE : OE_N_DRIVE; // see (RULE10)
            end
          end
        end
        ST_RD_ACK: begin
          if (ev.rise) begin
            nack_seen_d = sda_s; // see (RULE17)
          end else if (ev.fall) begin
            if (nack_seen_q) begin
              state_d = ST_IGNORE; // see (RULE18)
              oe_n_d = OE_N_RELEASE;
              note_d.master_nack = 1'b1;
            end else begin
              state_d = ST_RD;
              tx_sh_d = tx_byte_in;
              oe_n_d = tx_byte_in[7] ? OE_N_RELEASE : OE_N_DRIVE;
              note_d.tx_load = 1'b1;
            end
          end
        end
        ST_IGNORE: begin
          oe_n_d = OE_N_RELEASE; // see (RULE21)
        end
        default: begin
          state_d = ST_IDLE;
          oe_n_d = OE_N_RELEASE;
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_RESET;
      nack_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      nack_seen_q <= nack_seen_d;
    end
  end

  // transmit shifter
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_sh_q <= BYTE_RESET;
    end else begin
      tx_sh_q <= tx_sh_d;
    end
  end

  // data line: only pulled low or released, changed after clock falls
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      oe_n_q <= OE_N_RELEASE;
      sda_out <= SDA_LOW;
    end else begin
      oe_n_q <= oe_n_d; // see (RULE8) (RULE20)
      sda_out <= SDA_LOW; // see (RULE20)
    end
  end

  assign sda_oe_n_out = oe_n_q;

  // transfer status towards the core
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      addressed_q <= 1'b0;
      read_q <= 1'b0;
    end else begin
      addressed_q <= addressed_d;
      read_q <= read_d;
    end
  end

  assign addressed_out = addressed_q;
  assign read_mode_out = read_q;

  // received bytes and one-cycle notices
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rx_out <= '0;
      note_out <= '0;
    end else begin
      rx_out.valid <= rx_valid_d;
      if (rx_valid_d) begin
        rx_out.data <= link_shift_q;
      end
      note_out <= note_d;
    end
  end

endmodule

/* tb/scisp_port_props.sv */
// assertion checker for the serial slave port, bound to its ports
`timescale 1ns/100ps
module scisp_port_props
  import scisp_pkg::*;
(
  // clock, reset and pins
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic addr_strap_pin_0_in,
  input wire logic addr_strap_pin_1_in,
  input wire logic addr_strap_pin_2_in,
  // core side
  input wire logic busy_in,
  input wire logic rx_accept_in,
  input wire logic [7:0] tx_byte_in,
  input wire scisp_rx_t rx_out,
  input wire scisp_note_t note_out,
  input wire logic addressed_out,
  input wire logic read_mode_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence start_seq;
    scl_in && $fell(sda_in) ##1 scl_in [*2];
  endsequence
  sequence stop_seq;
    addressed_out && scl_in && $rose(sda_in) ##1 scl_in [*3];
  endsequence

  a_start_seen:
    assert property (start_seq |-> ##[0:5] note_out.start)
    else $error("start not reported");
  a_stop_seen:
    assert property (stop_seq |-> ##[0:5] note_out.stop)
    else $error("stop not reported");
  a_sda_low_only:
    assert property (!sda_oe_n_out |-> !sda_out)
    else $error("data line driven high");
  a_change_scl_low:
    assert property ($changed(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("data changed outside clock low");
  a_ack_stands:
    assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*8])
    else $error("low level too short");
  a_addr_ack:
    assert property ($rose(addressed_out) |-> !sda_oe_n_out && !$past(busy_in, 2))
    else $error("address ack while busy or missing");
  a_rx_addressed:
    assert property (rx_out.valid |-> addressed_out && !read_mode_out)
    else $error("byte delivered while not addressed");
  a_load_read:
    assert property (note_out.tx_load |-> read_mode_out && addressed_out)
    else $error("load outside read mode");
  a_nack_release:
    assert property (note_out.master_nack |-> sda_oe_n_out [*8])
    else $error("data line held after host nack");
endmodule

bind scisp_port scisp_port_props u_props (.clk_in(clk_in),
  .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .addr_strap_pin_0_in(addr_strap_pin_0_in),
  .addr_strap_pin_1_in(addr_strap_pin_1_in),
  .addr_strap_pin_2_in(addr_strap_pin_2_in), .busy_in(busy_in),
  .rx_accept_in(rx_accept_in), .tx_byte_in(tx_byte_in),
  .rx_out(rx_out), .note_out(note_out),
  .addressed_out(addressed_out), .read_mode_out(read_mode_out));

/* tb/scisp_host.sv */
// host bus master model making the serial clock and data
`timescale 1ns/100ps
module scisp_host (
  // link tick and wire level
  input wire logic lclk_in,
  input wire logic sda_in,
  // clock and data drive; data 1 means released
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // one slot: data, clock high, sample, clock low
  task automatic cyc(input logic d0, input logic d2, input logic lo,
                     output logic r);
    @(posedge lclk_in);
    sda_out = d0;
    @(posedge lclk_in);
    scl_out = 1'b1;
    @(posedge lclk_in);
    r = sda_in;
    sda_out = d2;
    @(posedge lclk_in);
    if (lo) begin
      scl_out = 1'b0;
    end
  endtask

  task automatic start();
    logic r;
    cyc(1'b1, 1'b0, 1'b1, r);
  endtask

  // clock stays high after a stop
  task automatic stop();
    logic r;
    cyc(1'b0, 1'b1, 1'b0, r);
    repeat (3) @(posedge lclk_in);
  endtask

  // byte msb first, then the ninth slot with host level ma
  task automatic xfer(input logic [7:0] d, input logic ma,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      cyc(d[i], d[i], 1'b1, r);
      q[i] = r;
    end
    cyc(ma, ma, 1'b1, ack);
  endtask
endmodule

/* tb/sha_coprocessor_i2c_slave_port_tb.sv */
// self-checking bench for the serial slave port with a host model
`timescale 1ns/100ps
module sha_coprocessor_i2c_slave_port_tb;
  import scisp_pkg::*;
  logic clk_in = 1'b0;
  logic lclk = 1'b0;
  logic resetn = 1'b0;
  logic busy = 1'b0;
  logic accept = 1'b1;
  logic [2:0] strap = 3'h0;
  logic [7:0] tx_byte = 8'h00;
  logic scl, hsda, oe_n, sda_drv, addressed, read_mode, ack;
  logic [7:0] q;
  scisp_rx_t rx;
  scisp_note_t note;
  // pull-up with two open-drain drivers
  wire logic sda = hsda & (oe_n | sda_drv);
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int stops = 0;
  int exp_stops = 0;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];

  always #12.5 clk_in = ~clk_in;
  initial begin
    #13;
    forever #40 lclk = ~lclk;
  end

  scisp_port DUT (
    .clk_in(clk_in), .resetn_in(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_drv), .sda_oe_n_out(oe_n),
    .addr_strap_pin_0_in(strap[0]), .addr_strap_pin_1_in(strap[1]),
    .addr_strap_pin_2_in(strap[2]), .busy_in(busy),
    .rx_accept_in(accept), .tx_byte_in(tx_byte), .rx_out(rx),
    .note_out(note), .addressed_out(addressed), .read_mode_out(read_mode)
  );
  scisp_host host (.lclk_in(lclk), .sda_in(sda), .scl_out(scl),
    .sda_out(hsda));

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (note.tx_load === 1'b1) begin
      txq.push_back(tx_byte);
      tx_byte <= 8'($urandom);
    end
    if (rx.valid === 1'b1) begin
      rxq.push_back(rx.data);
    end
    if (note.stop === 1'b1) begin
      stops <= stops + 1;
    end
    if (cycles > 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [6:0] own(input logic [2:0] s);
    logic [6:0] a;
    a = ADDR_BASE;
    a[0] = s[0];
    a[2] = s[1];
    a[4] = s[2];
    return a;
  endfunction

  task automatic do_reset(input logic [2:0] s);
    @(posedge clk_in);
    resetn <= 1'b0;
    strap <= s;
    repeat (16) @(posedge clk_in);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk_bit(oe_n, 1'b1);
  endtask

  // start, address byte, expected ninth-slot level
  task automatic addr(input logic [6:0] a, input logic rw, input logic e);
    host.start();
    host.xfer({a, rw}, 1'b1, q, ack);
    chk_bit(ack, e);
  endtask

  task automatic wr(input logic [7:0] d, input logic acc);
    @(posedge clk_in);
    accept <= acc;
    host.xfer(d, 1'b1, q, ack);
    chk_bit(ack, !acc);
    chk_byte(rxq.size() > 0 ? rxq.pop_front() : 8'hXX, d);
  endtask

  task automatic rd(input logic ma);
    host.xfer(8'hFF, ma, q, ack);
    chk_byte(q, txq.size() > 0 ? txq.pop_front() : 8'hXX);
  endtask

  initial begin
    void'($urandom(32'hA159147F));
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      addr(own(3'(s + 1)), 1'b0, 1'b1);
      host.xfer(8'h00, 1'b1, q, ack);
      chk_bit(ack, 1'b1);
      host.stop();
      addr(own(3'(s)), 1'b0, 1'b0);
      host.stop();
      exp_stops++;
    end
    do_reset(3'($urandom));
    busy <= 1'b1;
    addr(own(strap), 1'b0, 1'b1);
    busy <= 1'b0;
    addr(own(strap), 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(8'($urandom), 1'($urandom));
    end
    addr(own(strap), 1'b1, 1'b0);
    rd(1'b0);
    rd(1'b0);
    rd(1'b1);
    host.stop();
    exp_stops++;
    repeat (8) @(posedge clk_in);
    chk_byte(8'(stops), 8'(exp_stops));
    give_verdict();
  end
endmodule
